// ===== design/imp_consts.vh
// Functional notes
// RULE1 - after reset input a drives channel 2, input b drives channel 3
// RULE2 - software remaps each input's channels; input a map wins on overlap
// RULE3 - channel request is OR of spi bit, mapped pwm and mapped inputs; code adds spi and pwm only in active mode
// RULE4 - both parallel input levels are readable in the pin status word
// RULE5 - pin status keeps updating in limp-home mode
// RULE6 - idle low with any input high enters limp-home mode
// RULE7 - idle low with both inputs low enters sleep mode
// RULE8 - host holds idle level at least the longest idle filter time
// RULE9 - sleep entry returns all software registers to defaults
// RULE10 - sleep drops undervoltage monitor enables on io and battery supply
// RULE11 - sleep keeps serial output high impedance and ignores spi transfers
// RULE12 - unmasked low reset pin holds internal reset, outputs off, defaults
// RULE13 - reset pin ignored until software sets its unmask bit
// RULE14 - unmasked high kill pin forces every channel off
// RULE15 - kill pin low lets channels follow normal requests
// RULE16 - kill pin masked until software sets its unmask bit
// RULE17 - kill pin level is readable in the pin status word
// RULE18 - unmask bits set on large package, kept zero on small package
// RULE19 - active to sleep only when no channel is switched on
// RULE20 - any register reset, sleep included, re-masks both pins
`ifndef IMP_CONSTS_VH
`define IMP_CONSTS_VH
`define IMP_MAP_A_RST 8'h04
`define IMP_MAP_B_RST 8'h08
`define IMP_SPI_CMD_RST 8'h00
`define IMP_UNMASK_RST 1'b0
`define IMP_ST_SLEEP 2'h0
`define IMP_ST_IDLE 2'h1
`define IMP_ST_ACTIVE 2'h2
`define IMP_ST_LIMP 2'h3
`define IMP_STAT_IN_A 0
`define IMP_STAT_IN_B 1
`define IMP_STAT_KILL 2
`define IMP_STAT_W 3
`endif

// ===== design/imp_input_mapping.v
`include "imp_consts.vh"
`default_nettype none
module imp_input_mapping #(
    parameter CH = 8
) (
    input wire clk,
    input wire nrst,
    input wire parallelCmdInA,
    input wire parallelCmdInB,
    input wire idlePin,
    input wire externalResetN,
    input wire channelKillPin,
    input wire chipSelectN,
    input wire cfgWrEn,
    input wire [CH-1:0] cfgInputAChannelMap,
    input wire [CH-1:0] cfgInputBChannelMap,
    input wire [CH-1:0] cfgSpiCmd,
    input wire cfgKillPinUnmask,
    input wire cfgResetPinUnmask,
    input wire [CH-1:0] pwmMapped,
    output reg [CH-1:0] channelOn,
    output reg [`IMP_STAT_W-1:0] pinStatusWord,
    output reg [1:0] modeState,
    output reg uvMonEnable,
    output reg serialOutEnable,
    output reg spiAccept,
    output reg [CH-1:0] inputAChannelMap,
    output reg [CH-1:0] inputBChannelMap,
    output reg killPinUnmask,
    output reg resetPinUnmask
);
    // reset release through two flops
    reg rstSync1_q;
    reg rstSync2_q;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rstSync1_q <= 1'b0;
            rstSync2_q <= 1'b0;
        end else begin
            rstSync1_q <= 1'b1;
            rstSync2_q <= rstSync1_q;
        end
    end
    wire rstN = rstSync2_q;

    // pins are asynchronous: two flops before use
    reg [4:0] pinMeta_q;
    reg [4:0] pinSync_q;
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pinMeta_q <= 5'h00;
            pinSync_q <= 5'h00;
        end else begin
            pinMeta_q <= {chipSelectN, channelKillPin, externalResetN,
                idlePin, parallelCmdInB};
            pinSync_q <= pinMeta_q;
        end
    end
    reg inAMeta_q;
    reg inASync_q;
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            inAMeta_q <= 1'b0;
            inASync_q <= 1'b0;
        end else begin
            inAMeta_q <= parallelCmdInA;
            inASync_q <= inAMeta_q;
        end
    end
    wire inA = inASync_q;
    wire inB = pinSync_q[0];
    wire idleLvl = pinSync_q[1];
    wire extRstN = pinSync_q[2];
    wire killLvl = pinSync_q[3];
    wire csN = pinSync_q[4];

    // register reset: sleep or unmasked external reset low
    wire sleepNow = (modeState == `IMP_ST_SLEEP);
    wire extRstHold = resetPinUnmask & ~extRstN; // [RULE12]
    wire regClear = sleepNow | extRstHold; // [RULE9] [RULE12]

    // software settings; writes refused in sleep
    reg [CH-1:0] spiCmd_q;
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            inputAChannelMap <= `IMP_MAP_A_RST; // [RULE1]
            inputBChannelMap <= `IMP_MAP_B_RST; // [RULE1]
            spiCmd_q <= `IMP_SPI_CMD_RST;
            killPinUnmask <= `IMP_UNMASK_RST; // [RULE16]
            resetPinUnmask <= `IMP_UNMASK_RST; // [RULE13]
        end else if (regClear) begin
            inputAChannelMap <= `IMP_MAP_A_RST; // [RULE9]
            inputBChannelMap <= `IMP_MAP_B_RST;
            spiCmd_q <= `IMP_SPI_CMD_RST;
            killPinUnmask <= `IMP_UNMASK_RST; // [RULE20]
            resetPinUnmask <= `IMP_UNMASK_RST; // [RULE20]
        end else if (cfgWrEn) begin
            inputAChannelMap <= cfgInputAChannelMap; // [RULE2]
            inputBChannelMap <= cfgInputBChannelMap; // [RULE2]
            spiCmd_q <= cfgSpiCmd;
            killPinUnmask <= cfgKillPinUnmask; // [RULE16]
            resetPinUnmask <= cfgResetPinUnmask; // [RULE13]
        end
    end

    // mode decode shared by the request gating and the sleep-side outputs
    function isAwake;
        input [1:0] mode;
        begin
            isAwake = (mode != `IMP_ST_SLEEP);
        end
    endfunction

    function isActive;
        input [1:0] mode;
        begin
            isActive = (mode == `IMP_ST_ACTIVE);
        end
    endfunction

    // input a claims first; b only reaches channels a has not mapped
    wire [CH-1:0] mapB = inputBChannelMap & ~inputAChannelMap; // [RULE2]
    wire activeNow = isActive(modeState);
    wire [CH-1:0] req;
    wire [CH-1:0] wakeReq;

    // per-channel request; spi and pwm drive only in active mode
    genvar ch;
    generate
        for (ch = 0; ch < CH; ch = ch + 1) begin : gChan
            wire fromA = inA & inputAChannelMap[ch];
            wire fromB = inB & mapB[ch]; // [RULE2]
            wire fromSpi = spiCmd_q[ch];
            wire fromPwm = pwmMapped[ch];
            assign req[ch] = fromA | fromB
                | (activeNow & (fromSpi | fromPwm)); // [RULE3]
            // any source may wake idle, else spi could never reach active
            assign wakeReq[ch] = fromA | fromB | fromSpi | fromPwm;
        end
    endgenerate

    wire killForce = killPinUnmask & killLvl; // [RULE14]

    // channel drive
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            channelOn <= {CH{1'b0}};
        end else if (killForce | extRstHold | sleepNow) begin
            channelOn <= {CH{1'b0}}; // [RULE14] [RULE12]
        end else begin
            channelOn <= req; // [RULE15]
        end
    end

    // status follows pins in every mode, limp-home included
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pinStatusWord <= {`IMP_STAT_W{1'b0}};
        end else begin
            pinStatusWord[`IMP_STAT_IN_A] <= inA; // [RULE4] [RULE5]
            pinStatusWord[`IMP_STAT_IN_B] <= inB; // [RULE4]
            pinStatusWord[`IMP_STAT_KILL] <= killLvl; // [RULE17]
        end
    end

    // mode machine; idle is assumed held past its filter time
    reg [1:0] mode_d;
    always @* begin
        mode_d = modeState;
        case (modeState)
            `IMP_ST_SLEEP: begin
                if (idleLvl)
                    mode_d = `IMP_ST_IDLE;
                else if (inA | inB)
                    mode_d = `IMP_ST_LIMP; // [RULE6] [RULE8]
            end
            `IMP_ST_IDLE: begin
                if (!idleLvl)
                    mode_d = (inA | inB) ? `IMP_ST_LIMP : `IMP_ST_SLEEP;
                else if (|wakeReq)
                    mode_d = `IMP_ST_ACTIVE;
            end
            `IMP_ST_ACTIVE: begin
                if (!idleLvl && (inA | inB))
                    mode_d = `IMP_ST_LIMP; // [RULE6]
                else if (!idleLvl && !(|channelOn))
                    mode_d = `IMP_ST_SLEEP; // [RULE7] [RULE19]
            end
            `IMP_ST_LIMP: begin
                if (idleLvl)
                    mode_d = `IMP_ST_ACTIVE;
                else if (!(inA | inB))
                    mode_d = `IMP_ST_SLEEP; // [RULE7]
            end
            default: mode_d = `IMP_ST_SLEEP;
        endcase
    end

    always @(posedge clk or negedge rstN) begin
        if (!rstN)
            modeState <= `IMP_ST_SLEEP;
        else
            modeState <= mode_d;
    end

    // sleep-side outputs; spi refused and output floated while asleep
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            uvMonEnable <= 1'b0;
            serialOutEnable <= 1'b0;
            spiAccept <= 1'b0;
        end else begin
            uvMonEnable <= isAwake(mode_d); // [RULE10]
            spiAccept <= isAwake(mode_d); // [RULE11]
            serialOutEnable <= isAwake(mode_d) & ~csN; // [RULE11]
        end
    end
endmodule // imp_input_mapping
`default_nettype wire

// ===== tb/imp_input_mapping_checker.sv
`default_nettype none
module imp_input_mapping_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic parallelCmdInA,
    input wire logic externalResetN,
    input wire logic channelKillPin,
    input wire logic cfgWrEn,
    input wire logic [7:0] cfgInputAChannelMap,
    input wire logic [7:0] channelOn,
    input wire logic [2:0] pinStatusWord,
    input wire logic [1:0] modeState,
    input wire logic uvMonEnable,
    input wire logic serialOutEnable,
    input wire logic spiAccept,
    input wire logic [7:0] inputAChannelMap,
    input wire logic killPinUnmask,
    input wire logic resetPinUnmask
);
timeunit 1ns;
timeprecision 1ns;
default clocking @(posedge clk); endclocking
default disable iff (!nrst);
// steady pins must show after the sync delay; the check is skipped in sleep
chk_status_in_a: assert property ($stable(parallelCmdInA) [*6]
    |-> modeState == 2'h0 || pinStatusWord[0] == parallelCmdInA)
    else $error("status a");
chk_status_kill: assert property ($stable(channelKillPin) [*6]
    |-> modeState == 2'h0 || pinStatusWord[2] == channelKillPin)
    else $error("status kill");
chk_kill_forces: assert property (
    (killPinUnmask && channelKillPin) [*5] |-> channelOn == 8'h00)
    else $error("kill ignored");
chk_sleep_uv: assert property (modeState == 2'h0 [*2] |-> !uvMonEnable)
    else $error("uv on in sleep");
chk_sleep_serial: assert property (modeState == 2'h0 [*2]
    |-> !serialOutEnable && !spiAccept) else $error("serial on in sleep");
chk_sleep_clears: assert property (
    modeState == 2'h0 [*2] |-> inputAChannelMap == 8'h04
    && !killPinUnmask && !resetPinUnmask) else $error("no clear");
chk_reset_pin: assert property (resetPinUnmask && !externalResetN
    |-> ##[0:4] channelOn == 8'h00) else $error("reset pin ignored");
chk_write_taken: assert property (
    cfgWrEn && externalResetN && modeState != 2'h0 ##1 modeState != 2'h0
    |-> inputAChannelMap == $past(cfgInputAChannelMap))
    else $error("write lost");
endmodule // imp_input_mapping_checker
bind imp_input_mapping imp_input_mapping_checker chk_u (.*);
`default_nettype wire

// ===== tb/imp_host_model.sv
`default_nettype none
module imp_host_model #(
    parameter int IDLE_HOLD = 6 // idle filter span in clocks, plain default
) (
    input wire logic clk,
    output logic parallelCmdInA,
    output logic parallelCmdInB,
    output logic idlePin,
    output logic channelKillPin,
    output logic externalResetN,
    output logic chipSelectN,
    output logic cfgWrEn,
    output logic [7:0] cfgInputAChannelMap,
    output logic [7:0] cfgInputBChannelMap,
    output logic cfgKillPinUnmask,
    output logic cfgResetPinUnmask
);
timeunit 1ns;
timeprecision 1ns;
// input, idle and kill pins start low, as the pull-downs would leave them; reset and select start high
initial begin
    {parallelCmdInA, parallelCmdInB, idlePin, channelKillPin} = 4'h0;
    {externalResetN, chipSelectN, cfgWrEn} = 3'h6;
    {cfgInputAChannelMap, cfgInputBChannelMap} = 16'h0408;
    {cfgKillPinUnmask, cfgResetPinUnmask} = 2'h0;
end
// pins move at the falling edge, then stay past the idle filter
task automatic pins(input logic a, b, idle, kill, rstN);
    @(negedge clk);
    {parallelCmdInA, parallelCmdInB, idlePin} = {a, b, idle};
    {channelKillPin, externalResetN} = {kill, rstN};
    repeat (IDLE_HOLD) @(negedge clk);
endtask
// one-cycle settings write; unmask bits as on the large package
task automatic cfg(input logic [7:0] ma, mb, input logic ku, ru);
    @(negedge clk);
    {cfgInputAChannelMap, cfgInputBChannelMap} = {ma, mb};
    {cfgKillPinUnmask, cfgResetPinUnmask, cfgWrEn} = {ku, ru, 1'b1};
    @(negedge clk);
    cfgWrEn = 1'b0;
    repeat (2) @(negedge clk);
endtask
endmodule // imp_host_model
`default_nettype wire

// ===== tb/test_imp_input_mapping.sv
`default_nettype none
module test_imp_input_mapping;
timeunit 1ns;
timeprecision 1ns;
logic clk = 1'b0;
logic nrst = 1'b0;
logic parallelCmdInA, parallelCmdInB, idlePin, channelKillPin, externalResetN;
logic chipSelectN, cfgWrEn, cfgKillPinUnmask, cfgResetPinUnmask;
logic [7:0] cfgInputAChannelMap, cfgInputBChannelMap, channelOn, ma, mb;
logic [7:0] e0;
logic [7:0] cfgSpiCmd = 8'h00; // spi and pwm sources held at zero except during the kill test
logic [7:0] pwmMapped = 8'h00;
logic [7:0] inputAChannelMap, inputBChannelMap;
logic [2:0] pinStatusWord;
logic [1:0] modeState;
logic uvMonEnable, serialOutEnable, spiAccept, killPinUnmask, resetPinUnmask;
int num_errors = 0;
int n_tests = 0;
int seed = 32'hec03f05c;
logic [7:0] expQ[$];
int selQ[$];
string nm[6] = '{"channelOn", "status", "mode", "mapA", "flags", "mapB"};
event sampleEv;
imp_input_mapping dut_u (.*);
imp_host_model host_u (.*);
initial forever #50 clk = ~clk;
task automatic note(input int s, input logic [7:0] e);
    selQ.push_back(s);
    expQ.push_back(e);
endtask
task automatic cmp(input int s, input logic [7:0] e);
    logic [7:0] g;
    g = s == 0 ? channelOn : s == 1 ? {5'h00, pinStatusWord} :
        s == 2 ? {6'h00, modeState} : s == 3 ? inputAChannelMap :
        s == 5 ? inputBChannelMap :
        {3'h0, uvMonEnable, serialOutEnable, spiAccept, killPinUnmask,
        resetPinUnmask};
    n_tests++;
    if (g !== e) begin
        num_errors++;
        $display("ERROR %s expected %h seen %h", nm[s], e, g);
    end
endtask
task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
endtask
// the watcher compares each note once the outputs have settled
initial forever begin
    @(sampleEv);
    while (expQ.size() > 0) cmp(selQ.pop_front(), expQ.pop_front());
end
initial begin
    #(2000 * 100);
    num_errors++;
    final_report();
end
initial begin
    {ma, mb} = 16'h0408;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    host_u.pins(0, 0, 1, 1, 1);
    for (int i = 0; i < 5; i++) begin
        if (i > 0) begin
            ma = $random(seed);
            mb = $random(seed);
            host_u.cfg(ma, mb, 1'b0, 1'b0);
        end
        for (int c = 1; c < 4; c++) begin
            host_u.pins(c[0], c[1], 1'b1, 1'b1, 1'b1);
            e0 = (c[0] ? ma : 8'h00) | (c[1] ? mb & ~ma : 8'h00);
            note(0, e0);
            note(1, {5'h00, 1'b1, c[1:0]});
            note(5, mb);
            -> sampleEv;
        end
    end
    $display("mapping test done");
    cfgSpiCmd = 8'h20;
    host_u.cfg(8'h04, 8'h08, 1'b1, 1'b0);
    host_u.pins(1, 1, 1, 1, 1);
    note(0, 8'h00);
    -> sampleEv;
    pwmMapped = 8'h40;
    host_u.pins(1, 1, 1, 0, 1);
    note(0, 8'h6C);
    -> sampleEv;
    {cfgSpiCmd, pwmMapped} = 16'h0000;
    $display("kill test done");
    host_u.pins(1, 0, 1, 0, 0);
    host_u.cfg(8'hF0, 8'h00, 1'b0, 1'b0);
    note(3, 8'hF0);
    -> sampleEv;
    host_u.cfg(8'hF0, 8'h00, 1'b0, 1'b1);
    note(3, 8'h04);
    -> sampleEv;
    host_u.pins(1, 0, 1, 0, 1);
    $display("reset pin test done");
    host_u.cfg(8'h81, 8'h00, 1'b1, 1'b1);
    host_u.pins(1, 0, 0, 0, 1);
    note(2, 8'h03);
    -> sampleEv;
    host_u.pins(1, 1, 0, 0, 1);
    note(1, 8'h03);
    -> sampleEv;
    host_u.pins(0, 0, 0, 0, 1);
    note(2, 8'h00);
    note(3, 8'h04);
    note(4, 8'h00);
    -> sampleEv;
    $display("mode test done");
    @(negedge clk);
    final_report();
end
endmodule // test_imp_input_mapping
`default_nettype wire
